// >>> hdl/adccsr_pkg.sv
/*
 Shared constants for the converter start and serial readout block.
 Assumes a 25 MHz system clock; no software-visible registers.
*/
package adccsr_pkg;
   localparam int RESULT_BITS   = 18;
   localparam int CLK_PERIOD_NS = 40;
   // Conversion times in nanoseconds
   localparam int CONV_MIN_NS   = 500;
   localparam int CONV_MAX_HI_NS = 2200;
   localparam int CONV_MAX_LO_NS = 3700;
   // Minimum time rounds up, maximum rounds down
   localparam int CONV_MIN_CYC  = (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_MAX_HI_CYC = CONV_MAX_HI_NS / CLK_PERIOD_NS;
   localparam int CONV_MAX_LO_CYC = CONV_MAX_LO_NS / CLK_PERIOD_NS;
   // Cycles from a start pin edge to its synchronised edge
   localparam int SYNC_LAT_CYC  = 3;
   localparam int FIFO_DEPTH    = 8;
   localparam logic [17:0] RESULT_RESET = 18'h00000;
   typedef enum logic [1:0] {ADCCSR_IDLE, ADCCSR_CONV, ADCCSR_DONE} adccsr_phase_t;
endpackage

// >>> hdl/adccsr_fifo.sv
/*
 Small synchronous FIFO with valid/ready on both sides.
 Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module adccsr_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0]   wrPtr;
      logic [AW:0]   rdPtr;
      logic          isFull;
   } adccsr_fifo_st_t;
   adccsr_fifo_st_t   st_reg;
   adccsr_fifo_st_t   st_next;
   logic [WIDTH-1:0]  mem [DEPTH];
   logic              full;
   logic              empty;
   logic              push;
   logic              pop;

   assign empty    = st_reg.wrPtr == st_reg.rdPtr;
   assign full     = st_reg.isFull;
   assign inReady  = !full;
   assign outValid = !empty;
   assign outData  = mem[st_reg.rdPtr[AW-1:0]];
   assign push     = inValid && !full;
   assign pop      = outReady && !empty;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wrPtr = st_reg.wrPtr + 1'b1;
      end
      if (pop) begin
         st_next.rdPtr = st_reg.rdPtr + 1'b1;
      end
      // Registered full flag keeps the ready output off combinational paths
      st_next.isFull = (st_next.wrPtr[AW] != st_next.rdPtr[AW]) &&
                       (st_next.wrPtr[AW-1:0] == st_next.rdPtr[AW-1:0]);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
      if (push) begin
         mem[st_reg.wrPtr[AW-1:0]] <= inData;
      end
   end
endmodule
`default_nettype wire

// >>> hdl/adccsr_core.sv
/*
 Converter start and serial readout logic: conversion timer, mode
 selection, select-gated and daisy-chain shift paths.
 Assumes the host drives start, shift clock and serial input as pins
 asynchronous to clk; results arrive from the converter core as words.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Result ready 0.5 to 2.2 us after start rise, 3.7 us at low supply.
// - Select-gated mode shows the top result bit first, MSB first.
// - Select-gated output released when start or select rises, or after last bit.
// - Select level sampled at the start rising edge.
// - Shift clock level sampled at the start rising edge in chain mode.
// - Chain mode captures serial input on each shift clock fall.
// - Chain busy mode passes the serial input level, high or low, through to output.
// - Output moves to the next bit after each shift clock fall.
// - Chain mode when serial input low at start rise, else select-gated.
// - Result is an 18-bit two's complement serial word.
// - Chain input reappears on output after 18 shift clocks.
// - Select-gated mode drives output only while start is low.
module adccsr_core #(
   parameter int RESULT_BITS = adccsr_pkg::RESULT_BITS,
   parameter int FIFO_DEPTH  = adccsr_pkg::FIFO_DEPTH
) (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic                   lowSupply,
   input  wire logic                   convertStartPin,
   input  wire logic                   shiftClkPin,
   input  wire logic                   serialInModeSelectPin,
   input  wire logic                   resultValid,
   output logic                        resultReady,
   input  wire logic [RESULT_BITS-1:0] resultData,
   output logic                        serialOut,
   output logic                        serialOutEn,
   output logic                        chainMode,
   output logic                        converting
);
   localparam int CW = 8;
   localparam int BW = $clog2(RESULT_BITS + 1);
   localparam logic [CW-1:0] MIN_CYC = CW'(adccsr_pkg::CONV_MIN_CYC);
   // Limits count from the synchronised edge, so the pin latency is taken off
   localparam logic [CW-1:0] MAX_HI  = CW'(adccsr_pkg::CONV_MAX_HI_CYC - adccsr_pkg::SYNC_LAT_CYC);
   localparam logic [CW-1:0] MAX_LO  = CW'(adccsr_pkg::CONV_MAX_LO_CYC - adccsr_pkg::SYNC_LAT_CYC);
   localparam logic [BW-1:0] NBITS   = BW'(RESULT_BITS);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   // The stages sit in the state struct; the third start and shift
   // stage only feeds the edge detectors
   logic convert_start;
   logic cnvRise;
   logic sck;
   logic sckFall;
   logic serial_in_mode_select;

   // ---------------------------------------------------------------
   // Result FIFO
   // ---------------------------------------------------------------
   logic                   fifoValid;
   logic                   fifoPop;
   logic [RESULT_BITS-1:0] fifoData;
   adccsr_fifo #(.WIDTH(RESULT_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk      (clk),
      .rst_n    (rst_n),
      .inValid  (resultValid),
      .inReady  (resultReady),
      .inData   (resultData),
      .outValid (fifoValid),
      .outReady (fifoPop),
      .outData  (fifoData)
   );

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      adccsr_pkg::adccsr_phase_t phase;
      logic [CW-1:0]             cnt;
      logic                      chain;
      logic                      busyMode;
      logic [RESULT_BITS-1:0]    shift;
      logic [BW-1:0]             left;
      logic                      out;
      logic                      outEn;
      logic [2:0]                cnvSync;
      logic [2:0]                sckSync;
      logic [1:0]                sdiSync;
      logic                      convFlag;
   } adccsr_st_t;
   adccsr_st_t st_reg;
   adccsr_st_t st_next;

   assign convert_start     = st_reg.cnvSync[1];
   assign cnvRise = st_reg.cnvSync[1] && !st_reg.cnvSync[2];
   assign sck     = st_reg.sckSync[1];
   assign sckFall = !st_reg.sckSync[1] && st_reg.sckSync[2];
   assign serial_in_mode_select     = st_reg.sdiSync[1];

   always_comb begin
      st_next = st_reg;
      fifoPop = 1'b0;
      // Two flops per pin before any logic reads it
      st_next.cnvSync = {st_reg.cnvSync[1:0], convertStartPin};
      st_next.sckSync = {st_reg.sckSync[1:0], shiftClkPin};
      st_next.sdiSync = {st_reg.sdiSync[0], serialInModeSelectPin};
      if (cnvRise) begin
         st_next.chain    = !serial_in_mode_select;
         st_next.busyMode = !serial_in_mode_select && sck;
         st_next.phase    = adccsr_pkg::ADCCSR_CONV;
         st_next.cnt      = '0;
         st_next.outEn    = st_reg.chain && !serial_in_mode_select;
      end else begin
         case (st_reg.phase)
            adccsr_pkg::ADCCSR_CONV: begin
               st_next.cnt = st_reg.cnt + 1'b1;
               // Take the word once the minimum time is met, give up at the limit
               if ((st_reg.cnt + 1'b1 >= MIN_CYC && fifoValid) ||
                   st_reg.cnt + 1'b1 >= (lowSupply ? MAX_LO : MAX_HI)) begin
                  fifoPop       = fifoValid;
                  st_next.shift = fifoValid ? fifoData : adccsr_pkg::RESULT_RESET;
                  st_next.left  = NBITS;
                  st_next.phase = adccsr_pkg::ADCCSR_DONE;
               end
            end
            adccsr_pkg::ADCCSR_DONE,
            adccsr_pkg::ADCCSR_IDLE: begin
            end
            default: begin
               st_next.phase = adccsr_pkg::ADCCSR_IDLE;
            end
         endcase
         if (!st_reg.chain) begin
            // Select-gated: enable while start and select low, MSB first
            if (convert_start || serial_in_mode_select) begin
               st_next.outEn = 1'b0;
            end else if (st_reg.phase == adccsr_pkg::ADCCSR_DONE && st_reg.left != '0) begin
               st_next.outEn = 1'b1;
               st_next.out   = st_reg.shift[RESULT_BITS-1];
               if (sckFall) begin
                  st_next.shift = {st_reg.shift[RESULT_BITS-2:0], 1'b0};
                  st_next.left  = st_reg.left - 1'b1;
                  if (st_reg.left == BW'(1)) begin
                     st_next.outEn = 1'b0;
                  end else begin
                     st_next.out = st_reg.shift[RESULT_BITS-2];
                  end
               end
            end
         end else begin
            st_next.outEn = 1'b1;
            if (sckFall) begin
               // Chain: shift in serial input, delayed by the word length
               st_next.shift = {st_reg.shift[RESULT_BITS-2:0], serial_in_mode_select};
               st_next.out   = st_reg.shift[RESULT_BITS-2];
            end else if (st_reg.phase == adccsr_pkg::ADCCSR_DONE) begin
               st_next.out = st_reg.shift[RESULT_BITS-1];
            end else if (st_reg.busyMode) begin
               st_next.out = serial_in_mode_select;
            end
         end
      end
      // Registered so the converting output comes from a flop
      st_next.convFlag = st_next.phase == adccsr_pkg::ADCCSR_CONV;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg       <= '0;
         st_reg.phase <= adccsr_pkg::ADCCSR_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign serialOut   = st_reg.out;
   assign serialOutEn = st_reg.outEn;
   assign chainMode   = st_reg.chain;
   assign converting  = st_reg.convFlag;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_conv_bounded: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(converting) |-> ##[1:100] !converting)
      else $error("Conversion did not finish in time");
   a_gated_release: assert property (@(posedge clk) disable iff (!rst_n)
      (!chainMode && convert_start && !cnvRise) |=> !serialOutEn)
      else $error("Output driven while start high");
   a_mode_select: assert property (@(posedge clk) disable iff (!rst_n)
      cnvRise |=> chainMode == !$past(serial_in_mode_select))
      else $error("Mode not taken from select level");
   a_chain_shift: assert property (@(posedge clk) disable iff (!rst_n)
      (chainMode && sckFall && !cnvRise) |=> st_reg.shift[0] == $past(serial_in_mode_select))
      else $error("Chain bit not captured");
   a_msb_first: assert property (@(posedge clk) disable iff (!rst_n)
      (!chainMode && $rose(serialOutEn)) |-> st_reg.left == NBITS)
      else $error("First bit is not the top bit");
   a_last_release: assert property (@(posedge clk) disable iff (!rst_n)
      (!chainMode && !cnvRise && sckFall && serialOutEn && st_reg.left == BW'(1)) |=> !serialOutEn)
      else $error("Output not released after last bit");
   a_busy_pass: assert property (@(posedge clk) disable iff (!rst_n)
      (chainMode && st_reg.busyMode && !sckFall && !cnvRise &&
       st_reg.phase != adccsr_pkg::ADCCSR_DONE) |=> serialOut == $past(serial_in_mode_select))
      else $error("Chain input not passed through in busy mode");
   a_chain_drive: assert property (@(posedge clk) disable iff (!rst_n)
      (chainMode && !cnvRise) |=> serialOutEn)
      else $error("Chain output not driven");
endmodule
`default_nettype wire

// >>> tb/adccsr_host_model.sv
/*
 Host controller model: drives start, shift clock and select/chain data.
 Assumes the bench calls its tasks and that clk is the 25 MHz system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adccsr_host_model (
   input  wire logic clk,
   input  wire logic serialOut,
   output logic      startPin,
   output logic      shiftClk,
   output logic      selData
);
   initial begin
      startPin = 1'b0;
      shiftClk = 1'b1;
      selData  = 1'b1;
   end
   task automatic host_wait(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // ---------------------------------------------
   // Conversion request
   // ---------------------------------------------
   task automatic begin_conv(input logic sel, input logic sck);
      startPin = 1'b0;
      selData  = sel;
      shiftClk = sck;
      host_wait(4);
      startPin = 1'b1;
      host_wait(1);
   endtask
   task automatic open_gate();
      startPin = 1'b0;
      selData  = 1'b0;
      host_wait(4);
   endtask
   task automatic set_sel(input logic v);
      selData = v;
   endtask
   // ---------------------------------------------
   // Shift frame, 320 ns period, sampled before each fall
   // ---------------------------------------------
   task automatic shift_bits(input int n, input logic [35:0] din, output logic [35:0] dout);
      dout = 36'h000000000;
      if (shiftClk == 1'b0) begin
         shiftClk = 1'b1;
         host_wait(4);
      end
      for (int i = 0; i < n; i++) begin
         selData = din[35-i];
         host_wait(2);
         dout = {dout[34:0], serialOut};
         shiftClk = 1'b0;
         host_wait(4);
         shiftClk = 1'b1;
         host_wait(2);
      end
   endtask
endmodule
`default_nettype wire

// >>> tb/test_adc_convert_serial_readout.sv
/*
 Self-checking bench for the converter start and serial readout block.
 Assumes adccsr_pkg, adccsr_core, adccsr_fifo and the host model are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module test_adc_convert_serial_readout;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        lowSupply = 1'b0;
   logic        resultValid = 1'b0;
   logic [17:0] resultData = 18'h00000;
   logic        resultReady, serialOut, serialOutEn, chainMode, converting;
   logic        startPin, shiftClk, selData;
   logic [35:0] got;
   int          num_errors = 0;
   int          n_tests = 0;
   int          cycleCount = 0;
   always #20 clk = ~clk;
   adccsr_core adccsr_core_inst (.clk(clk), .rst_n(rst_n), .lowSupply(lowSupply),
      .convertStartPin(startPin), .shiftClkPin(shiftClk), .serialInModeSelectPin(selData),
      .resultValid(resultValid), .resultReady(resultReady), .resultData(resultData),
      .serialOut(serialOut), .serialOutEn(serialOutEn), .chainMode(chainMode), .converting(converting));
   adccsr_host_model adccsr_host_model_inst (.clk(clk), .serialOut(serialOut),
      .startPin(startPin), .shiftClk(shiftClk), .selData(selData));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic close_out();
      if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic [17:0] word_of(input int i);
      return 18'h2a5c3 + 18'(i) * 18'h0b1d7;
   endfunction
   task automatic conv_len(output int n);
      int c;
      c = 0;
      n = 0;
      while (converting !== 1'b1 && c < 8) begin
         step(1);
         c++;
      end
      while (converting === 1'b1 && n < 200) begin
         step(1);
         n++;
      end
   endtask
   always @(posedge clk) begin
      cycleCount <= cycleCount + 1;
      if (cycleCount == 20000) begin
         num_errors++;
         close_out();
      end
   end
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic sc_fill();
      for (int i = 0; i < 8; i++) begin
         check("ready", {35'h0, resultReady}, 36'h1);
         resultValid = 1'b1;
         resultData = word_of(i);
         step(1);
      end
      resultData = 18'h3ffff;
      step(2);
      check("ready full", {35'h0, resultReady}, 36'h0);
      resultValid = 1'b0;
   endtask
   task automatic sc_gated(input int i);
      int n;
      lowSupply = i[0];
      adccsr_host_model_inst.begin_conv(1'b1, 1'b1);
      conv_len(n);
      check("conv min", {35'h0, n >= adccsr_pkg::CONV_MIN_CYC}, 36'h1);
      check("mode", {35'h0, chainMode}, 36'h0);
      adccsr_host_model_inst.open_gate();
      check("drive", {35'h0, serialOutEn}, 36'h1);
      adccsr_host_model_inst.shift_bits(18, 36'h0, got);
      check("word", got, {18'h0, word_of(i)});
      check("release", {35'h0, serialOutEn}, 36'h0);
   endtask
   task automatic sc_chain();
      int n;
      adccsr_host_model_inst.begin_conv(1'b0, 1'b0);
      conv_len(n);
      check("chain mode", {35'h0, chainMode}, 36'h1);
      adccsr_host_model_inst.shift_bits(36, {18'h15a3c, 18'h0}, got);
      check("chain word", got, {word_of(6), 18'h15a3c});
   endtask
   task automatic sc_busy();
      int n;
      adccsr_host_model_inst.begin_conv(1'b0, 1'b1);
      step(2);
      adccsr_host_model_inst.set_sel(1'b1);
      step(4);
      check("busy pass high", {35'h0, serialOut}, 36'h1);
      adccsr_host_model_inst.set_sel(1'b0);
      step(4);
      check("busy pass low", {35'h0, serialOut}, 36'h0);
      conv_len(n);
      check("busy mode", {35'h0, chainMode}, 36'h1);
   endtask
   task automatic sc_timeout(input logic low);
      int n;
      int lim;
      lowSupply = low;
      lim = low ? adccsr_pkg::CONV_MAX_LO_CYC : adccsr_pkg::CONV_MAX_HI_CYC;
      adccsr_host_model_inst.begin_conv(1'b1, 1'b1);
      conv_len(n);
      n = n + adccsr_pkg::SYNC_LAT_CYC;
      check("conv max", {35'h0, n >= lim - 2 && n <= lim}, 36'h1);
      adccsr_host_model_inst.open_gate();
      adccsr_host_model_inst.shift_bits(18, 36'h0, got);
      check("empty word", got, 36'h0);
   endtask
   initial begin
      step(2);
      rst_n = 1'b1;
      step(3);
      sc_fill();
      for (int i = 0; i < 6; i++) sc_gated(i);
      sc_chain();
      sc_busy();
      sc_timeout(1'b0);
      sc_timeout(1'b1);
      close_out();
   end
endmodule
`default_nettype wire
